// ### hdl/pira_consts.svh
// Constants of the process image register access channel.
`ifndef PIRA_CONSTS_SVH
`define PIRA_CONSTS_SVH
`define PIRA_MODE_BIT      7
`define PIRA_DIR_BIT       6
`define PIRA_NUM_MSB       5
`define PIRA_REG_FW        6'h09
`define PIRA_REG_CODE      6'h1f
`define PIRA_REG_FEAT      6'h20
`define PIRA_UNLOCK_CODE   16'h1235
`define PIRA_RESET_WORD    16'h0000
`define PIRA_FW_DEFAULT    16'h3130
`define PIRA_NORMAL_CTRL   8'h00
`define PIRA_APB_CMD       12'h000
`define PIRA_APB_WDATA     12'h004
`define PIRA_APB_STAT      12'h008
`define PIRA_APB_RDATA     12'h00c
`define PIRA_STAT_BUSY     0
`define PIRA_STAT_DONE     1
`endif

// ### hdl/pira_pkg.sv
// Types shared by both ends of the register access channel.
package pira_pkg;
  `include "pira_consts.svh"

  typedef logic [7:0]  pira_byte_t;
  typedef logic [15:0] pira_word_t;
  typedef logic [5:0]  pira_num_t;

  typedef enum logic [1:0] {
    PIRA_H_IDLE  = 2'b00,
    PIRA_H_QUIET = 2'b01,
    PIRA_H_REQ   = 2'b10
  } pira_hstate_t;

  typedef struct packed {
    logic [63:0][15:0] mem;
  } pira_bank_st_t;

  typedef struct packed {
    pira_byte_t stat;
    pira_word_t din;
    logic       booted;
    pira_word_t feat_active;
    logic       wr_refused;
    logic       reg_mode;
    logic       unlocked;
  } pira_term_st_t;

  typedef struct packed {
    pira_hstate_t state;
    pira_num_t    num;
    logic         dir;
    pira_word_t   wdata;
    pira_word_t   rdata;
    pira_byte_t   ack;
    logic         done;
    pira_byte_t   ctrl;
    pira_word_t   dout;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } pira_host_st_t;

  function automatic pira_byte_t pira_ack_byte(input pira_byte_t ctrl);
    pira_byte_t a;
    a = ctrl;
    a[`PIRA_DIR_BIT] = 1'b0;
    return a;
  endfunction
endpackage

// ### hdl/pira_if.sv
// Three-byte process slot between host and terminal.
`timescale 1ns/100ps
interface pira_if;
  logic [7:0] ctrl_byte;
  logic [7:0] out_hi;
  logic [7:0] out_lo;
  logic [7:0] stat_byte;
  logic [7:0] in_hi;
  logic [7:0] in_lo;

  modport term (
    input  ctrl_byte,
    input  out_hi,
    input  out_lo,
    output stat_byte,
    output in_hi,
    output in_lo
  );

  modport host (
    output ctrl_byte,
    output out_hi,
    output out_lo,
    input  stat_byte,
    input  in_hi,
    input  in_lo
  );
endinterface

// ### hdl/pira_reg_bank.sv
// Storage of the 64 terminal registers.
`timescale 1ns/100ps
`include "pira_consts.svh"
module pira_reg_bank
  import pira_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire pira_pkg::pira_num_t  wr_num,
  input  wire pira_pkg::pira_word_t wr_data,
  input  wire pira_pkg::pira_num_t  rd_num,
  output pira_pkg::pira_word_t      rd_data,
  output pira_pkg::pira_word_t      code_word,
  output pira_pkg::pira_word_t      feat_word
);
  import pira_pkg::*;

  pira_bank_st_t st_r;
  pira_bank_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.mem[wr_num] = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data   = st_r.mem[rd_num];
  assign code_word = st_r.mem[`PIRA_REG_CODE];
  assign feat_word = st_r.mem[`PIRA_REG_FEAT];
endmodule

// ### hdl/pira_term.sv
// Terminal end of the process image register access channel.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "pira_consts.svh"
module pira_term
  import pira_pkg::*;
#(
  parameter pira_pkg::pira_word_t FW_VERSION = `PIRA_FW_DEFAULT
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  pira_if.term             slot,
  output pira_pkg::pira_word_t feature_active,
  output logic             unlocked,
  output logic             reg_mode,
  output logic             write_refused
);
  import pira_pkg::*;

  // The version value above is arbitrary.

  pira_term_st_t st_r;
  pira_term_st_t st_nxt;

  pira_byte_t ctrl;
  pira_word_t dout;
  pira_num_t  num;
  logic       mode_on;
  logic       is_write;
  logic       wr_ok;
  logic       bank_wr;
  pira_word_t bank_rd;
  pira_word_t code_word;
  pira_word_t feat_word;
  pira_word_t rd_value;
  logic       unlocked_now;

  // Decides whether a register may be written under the present lock.
  function automatic logic wr_allowed(input pira_num_t n,
                                      input logic      open);
    logic ok;
    ok = 1'b0;
    if (n == `PIRA_REG_CODE) begin
      ok = 1'b1;
    end else if (n == `PIRA_REG_FW) begin
      ok = 1'b0;
    end else begin
      ok = open;
    end
    return ok;
  endfunction

  // Selects what a read of a register shows.
  function automatic pira_word_t read_mux(input pira_num_t  n,
                                          input pira_word_t stored);
    pira_word_t v;
    v = stored;
    if (n == `PIRA_REG_FW) begin
      v = FW_VERSION;
    end
    return v;
  endfunction

  assign ctrl     = slot.ctrl_byte;
  assign dout     = {slot.out_hi, slot.out_lo};
  assign mode_on  = ctrl[`PIRA_MODE_BIT];
  assign is_write = ctrl[`PIRA_DIR_BIT];
  assign num      = ctrl[`PIRA_NUM_MSB:0];

  // The lock follows the code register word for word.
  assign unlocked_now = (code_word == `PIRA_UNLOCK_CODE);

  assign wr_ok   = wr_allowed(num, unlocked_now);
  assign bank_wr = mode_on && is_write && wr_ok;

  pira_reg_bank u_bank (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .wr_en     (bank_wr),
    .wr_num    (num),
    .wr_data   (dout),
    .rd_num    (num),
    .rd_data   (bank_rd),
    .code_word (code_word),
    .feat_word (feat_word)
  );

  assign rd_value = read_mux(num, bank_rd);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.reg_mode = mode_on;
    st_nxt.booted   = 1'b1;
    st_nxt.unlocked = unlocked_now;
    if (!st_r.booted) begin
      // The feature word takes effect only once after a restart.
      st_nxt.feat_active = feat_word;
    end
    if (!mode_on) begin
      st_nxt.stat       = `PIRA_NORMAL_CTRL;
      st_nxt.wr_refused = 1'b0;
    end else if (is_write) begin
      // The output word is taken only if wr_ok allows it, the input word is left stale.
      st_nxt.stat       = pira_ack_byte(ctrl);
      st_nxt.wr_refused = !wr_ok;
    end else begin
      // The output word plays no part in a read.
      st_nxt.stat       = ctrl;
      st_nxt.din        = rd_value;
      st_nxt.wr_refused = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign slot.stat_byte = st_r.stat;
  assign slot.in_hi     = st_r.din[15:8];
  assign slot.in_lo     = st_r.din[7:0];
  assign feature_active = st_r.feat_active;
  assign reg_mode       = st_r.reg_mode;
  assign write_refused  = st_r.wr_refused;

  assign unlocked       = st_r.unlocked;
endmodule

// ### hdl/pira_host.sv
// Host end: APB-controlled master of the register access channel.
`timescale 1ns/100ps
`include "pira_consts.svh"
module pira_host
  import pira_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  pira_if.host             slot
);
  import pira_pkg::*;

  pira_host_st_t st_r;
  pira_host_st_t st_nxt;
  pira_byte_t    req_ctrl;
  pira_byte_t    expect_ack;
  pira_byte_t    stat_in;
  logic          busy;

  assign stat_in    = slot.stat_byte;
  assign busy       = (st_r.state != PIRA_H_IDLE);
  assign req_ctrl   = {1'b1, st_r.dir, st_r.num};
  assign expect_ack = st_r.dir ? pira_ack_byte(req_ctrl) : req_ctrl;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.pready = 1'b0;
    if (psel && !penable) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = 1'b0;
      unique case (paddr)
        `PIRA_APB_CMD:   st_nxt.prdata = {25'h0, st_r.dir, st_r.num};
        `PIRA_APB_WDATA: st_nxt.prdata = {16'h0, st_r.wdata};
        `PIRA_APB_STAT:  st_nxt.prdata = {16'h0, st_r.ack, 6'h0,
                                          st_r.done, busy};
        `PIRA_APB_RDATA: st_nxt.prdata = {16'h0, st_r.rdata};
        default: begin
          st_nxt.prdata  = 32'h0;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_r.pready && pwrite) begin
      if (paddr == `PIRA_APB_WDATA) begin
        st_nxt.wdata = pwdata[15:0];
      end else if (paddr == `PIRA_APB_CMD && !busy) begin
        st_nxt.num   = pwdata[`PIRA_NUM_MSB:0];
        st_nxt.dir   = pwdata[`PIRA_DIR_BIT];
        st_nxt.done  = 1'b0;
        st_nxt.state = PIRA_H_QUIET;
      end
    end
    unique case (st_r.state)
      PIRA_H_IDLE: begin
        st_nxt.ctrl = `PIRA_NORMAL_CTRL;
      end
      PIRA_H_QUIET: begin
        // A fresh acknowledge is only trusted after normal mode is seen.
        if (!stat_in[`PIRA_MODE_BIT]) begin
          st_nxt.ctrl  = req_ctrl;
          st_nxt.dout  = st_r.wdata;
          st_nxt.state = PIRA_H_REQ;
        end
      end
      PIRA_H_REQ: begin
        if (stat_in == expect_ack) begin
          st_nxt.ack   = stat_in;
          st_nxt.done  = 1'b1;
          st_nxt.ctrl  = `PIRA_NORMAL_CTRL;
          st_nxt.state = PIRA_H_IDLE;
          if (!st_r.dir) begin
            st_nxt.rdata = {slot.in_hi, slot.in_lo};
          end
        end
      end
      default: begin
        st_nxt.state = PIRA_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata         = st_r.prdata;
  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign slot.ctrl_byte = st_r.ctrl;
  assign slot.out_hi    = st_r.dout[15:8];
  assign slot.out_lo    = st_r.dout[7:0];
endmodule

// ### dv/pira_chk.sv
// Checker of the slot between the host and terminal ends.
`timescale 1ns/100ps
module pira_chk
  import pira_pkg::*;
#(
  parameter pira_pkg::pira_word_t FW_VERSION = 16'h3130
)
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] ctrl_byte,
  input wire logic [7:0] out_hi,
  input wire logic [7:0] out_lo,
  input wire logic [7:0] stat_byte,
  input wire logic [7:0] in_hi,
  input wire logic [7:0] in_lo,
  input wire logic       reg_mode,
  input wire logic       write_refused
);
  import pira_pkg::*;

  typedef struct packed {
    pira_word_t code;
    pira_word_t feat;
    pira_word_t regx;
  } pira_shadow_t;

  pira_shadow_t sh_r;
  pira_shadow_t sh_nxt;
  logic         rd;
  logic         wr;
  pira_word_t   din;

  assign rd = ctrl_byte[7] & ~ctrl_byte[6];
  assign wr = ctrl_byte[7] & ctrl_byte[6];
  assign din = {in_hi, in_lo};

  // Shadow copies of the registers that the properties read back.
  always_comb begin
    sh_nxt = sh_r;
    if (ctrl_byte == 8'hdf) begin
      sh_nxt.code = {out_hi, out_lo};
    end
    if (sh_r.code == 16'h1235) begin
      if (ctrl_byte == 8'he0) begin
        sh_nxt.feat = {out_hi, out_lo};
      end
      if (ctrl_byte == 8'hc5) begin
        sh_nxt.regx = {out_hi, out_lo};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_idle_stat;
    !ctrl_byte[7] |=> stat_byte == 8'h00;
  endproperty
  a_idle_stat: assert property (p_idle_stat)
    else $error("status not cleared in normal mode");

  property p_rd_ack;
    rd |=> stat_byte == $past(ctrl_byte);
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("read acknowledge differs");

  property p_wr_ack;
    wr |=> stat_byte == ($past(ctrl_byte) & 8'hbf);
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write acknowledge differs");

  property p_wr_din;
    wr |=> $stable(din);
  endproperty
  a_wr_din: assert property (p_wr_din)
    else $error("input word moved during write");

  property p_fw;
    ctrl_byte == 8'h89 |=> din == FW_VERSION;
  endproperty
  a_fw: assert property (p_fw)
    else $error("version word wrong");

  property p_code_rd;
    ctrl_byte == 8'h9f |=> din == $past(sh_r.code);
  endproperty
  a_code_rd: assert property (p_code_rd)
    else $error("code word readback wrong");

  property p_feat_rd;
    ctrl_byte == 8'ha0 |=> din == $past(sh_r.feat);
  endproperty
  a_feat_rd: assert property (p_feat_rd)
    else $error("feature readback wrong");

  property p_lock_rd;
    ctrl_byte == 8'h85 |=> din == $past(sh_r.regx);
  endproperty
  a_lock_rd: assert property (p_lock_rd)
    else $error("protected register readback wrong");

  property p_mode_flag;
    ctrl_byte[7] |=> reg_mode;
  endproperty
  a_mode_flag: assert property (p_mode_flag)
    else $error("register mode flag not raised");

  property p_fw_refuse;
    wr && ctrl_byte[5:0] == 6'h09 |=> write_refused;
  endproperty
  a_fw_refuse: assert property (p_fw_refuse)
    else $error("version register write not refused");

  property p_lock_refuse;
    ctrl_byte == 8'hc5 && sh_r.code != 16'h1235 |=> write_refused;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("locked register write not refused");

  property p_code_take;
    ctrl_byte == 8'hdf |=> !write_refused;
  endproperty
  a_code_take: assert property (p_code_take)
    else $error("code register write refused");
endmodule

// ### dv/process_image_register_access_tb.sv
// Self-checking bench joining host and terminal ends over the slot.
`timescale 1ns/100ps
`include "pira_consts.svh"
module process_image_register_access_tb
  import pira_pkg::*;
;
  localparam pira_word_t FW = 16'h5a3c; // Arbitrary version value.
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, unl;
  logic        mode_flag, refused;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  pira_word_t  feat_act;
  pira_word_t  mdl [64];
  int          n_fail, checked;

  pira_if slot_if ();
  pira_host i_pira_host (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .slot(slot_if));
  pira_term #(.FW_VERSION(FW)) i_pira_term (.sys_clk(sys_clk),
    .rst_n(rst_n), .slot(slot_if), .feature_active(feat_act),
    .unlocked(unl), .reg_mode(mode_flag), .write_refused(refused));
  pira_chk #(.FW_VERSION(FW)) i_pira_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .ctrl_byte(slot_if.ctrl_byte), .out_hi(slot_if.out_hi),
    .out_lo(slot_if.out_lo), .stat_byte(slot_if.stat_byte),
    .in_hi(slot_if.in_hi), .in_lo(slot_if.in_lo),
    .reg_mode(mode_flag), .write_refused(refused));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One slot access through the host registers, checked against the model.
  task automatic acc(input logic w, input pira_num_t n, input pira_word_t d);
    logic [31:0] q;
    logic        e;
    pira_word_t  x;
    x = (n == `PIRA_REG_FW) ? FW : mdl[n];
    apb(1'b1, `PIRA_APB_WDATA, {16'h0000, d}, q, e);
    apb(1'b1, `PIRA_APB_CMD, {25'h0, w, n}, q, e);
    q = '0;
    while (q[`PIRA_STAT_DONE] !== 1'b1) apb(1'b0, `PIRA_APB_STAT, '0, q, e);
    chk("ack", {8'h00, q[15:8]}, {10'h002, n});
    apb(1'b0, `PIRA_APB_RDATA, '0, q, e);
    if (!w) begin
      chk("rdata", q[15:0], x);
    end else if (n == `PIRA_REG_CODE ||
                 (n != `PIRA_REG_FW && mdl[31] == 16'h1235)) begin
      mdl[n] = d;
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (mdl[i]) mdl[i] = '0;
  endtask

  initial begin
    logic [31:0] q;
    logic        e;
    pira_num_t   n;
    pira_word_t  d;
    n_fail = 0;
    checked = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h7f07e651));
    do_reset();
    acc(1'b0, 6'h09, 16'hffff);
    acc(1'b0, 6'h1f, 16'h0000);
    acc(1'b1, 6'h20, 16'h0002);
    acc(1'b0, 6'h20, 16'h0000);
    acc(1'b1, 6'h1f, 16'h1235);
    chk("unlock", {15'h0000, unl}, 16'h0001);
    acc(1'b0, 6'h1f, 16'h0000);
    acc(1'b1, 6'h20, 16'h0002);
    acc(1'b0, 6'h20, 16'h0000);
    acc(1'b1, 6'h09, 16'h1111);
    acc(1'b1, 6'h1f, 16'h0000);
    chk("relock", {15'h0000, unl}, 16'h0000);
    acc(1'b1, 6'h20, 16'h0040);
    acc(1'b0, 6'h20, 16'h0000);
    chk("feature", feat_act, 16'h0000);
    repeat (60) begin
      case ($urandom % 5)
        0: n = `PIRA_REG_FW;
        1: n = `PIRA_REG_CODE;
        2: n = `PIRA_REG_FEAT;
        3: n = 6'h05;
        default: n = 6'($urandom);
      endcase
      d = ($urandom % 3 == 0) ? 16'h1235 : 16'($urandom);
      acc(1'($urandom), n, d);
    end
    apb(1'b0, 12'h010, '0, q, e);
    chk("slverr", {15'h0000, e}, 16'h0001);
    chk("unmapped", q[15:0], 16'h0000);
    do_reset();
    acc(1'b0, 6'h20, 16'h0000);
    chk("restart", feat_act, 16'h0000);
    conclude();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
